// ### inc/wrf_pkg.sv
// Purpose: shared constants and carriers of the watchdog with reset-cause flags
// Assumes: 32-bit APB register access, byte addresses
// Notes: control and status layouts match the register bit order
`default_nettype none
package wrf_pkg;
	localparam logic [11:0] CTRL_ADDR = 12'h0_060;
	localparam logic [11:0] STAT_ADDR = 12'h0_064;
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int REG_W = 8;
	// time-out figures, in oscillator cycles
	localparam int DOG_BASE_CYC = 2048;
	localparam int DOG_MAX_CYC = 1048576;
	localparam logic [3:0] DOG_PS_LAST = 4'h9;
	localparam int DOG_CNT_W = 20;
	localparam int OSC_KHZ = 128;
	localparam int CLK_MHZ = 100;
	localparam int CE_WINDOW = 4;
	localparam logic [2:0] CE_CNT_W3 = 3'h4;
	localparam logic FUSE_PROGRAMMED = 1'b0;

	typedef struct packed {
		logic irq_flag;
		logic irq_en;
		logic ps_hi;
		logic change_en;
		logic reset_en;
		logic [2:0] ps_lo;
	} wrf_ctrl_s;

	typedef struct packed {
		logic [2:0] unused;
		logic debug_port;
		logic dog;
		logic supply_drop;
		logic pin;
		logic power_on;
	} wrf_stat_s;

	localparam wrf_ctrl_s CTRL_RST = 8'h00;
	localparam wrf_stat_s STAT_POR = 8'h01;

	typedef enum {
		WRF_STOPPED,
		WRF_IRQ,
		WRF_RESET,
		WRF_IRQ_RESET
	} wrf_mode_e;
endpackage
`default_nettype wire

// ### logic/wrf_watchdog.sv
// Purpose: watchdog timer with interrupt/reset modes and reset-cause status flags
// Assumes: resetn is the power-on reset; other reset sources arrive as one-cycle pulses
// Notes: the slow oscillator arrives as a level and is sampled on clk
`timescale 1ns/10ps
`default_nettype none

module wrf_watchdog #(
	parameter int CNT_W = wrf_pkg::DOG_CNT_W
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [wrf_pkg::ADDR_W-1:0] paddr,
	input wire logic [wrf_pkg::DATA_W-1:0] pwdata,
	output logic [wrf_pkg::DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic dog_osc_level,
	input wire logic dog_always_on_fuse,
	input wire logic global_irq_enable,
	input wire logic irq_vector_taken,
	input wire logic dog_restart,
	input wire logic debug_port_reset_in,
	input wire logic supply_drop_reset_in,
	input wire logic pin_reset_in,
	output logic dog_irq_req,
	output logic dog_sys_reset
);
	// the shifted period must fit the counter and stay inside an int
	if (CNT_W < wrf_pkg::DOG_CNT_W || CNT_W > 31) begin : g_bad_cnt_w
		$error("wrf_watchdog: CNT_W cannot hold the longest time-out");
	end
	// prescaler table and window length must agree with their limits
	if ((wrf_pkg::DOG_BASE_CYC << wrf_pkg::DOG_PS_LAST) != wrf_pkg::DOG_MAX_CYC) begin : g_bad_tbl
		$error("wrf_watchdog: prescaler table does not end at the longest period");
	end
	if (int'(wrf_pkg::CE_CNT_W3) != wrf_pkg::CE_WINDOW) begin : g_bad_win
		$error("wrf_watchdog: change window count disagrees with its length");
	end

	// change-window counter end points
	localparam logic [2:0] CE_LAST = 3'h1;
	localparam logic [2:0] CE_IDLE = 3'h0;

	// apb slave
	logic [wrf_pkg::DATA_W-1:0] prdata_r, prdata_nxt;
	logic pready_r, pready_nxt;
	logic pslverr_r, pslverr_nxt;
	logic setup, wr_ctrl, wr_stat, hit_ctrl, hit_stat;
	assign setup = psel && !penable;
	assign hit_ctrl = paddr == wrf_pkg::CTRL_ADDR;
	assign hit_stat = paddr == wrf_pkg::STAT_ADDR;
	assign wr_ctrl = psel && penable && pready_r && pwrite && hit_ctrl;
	assign wr_stat = psel && penable && pready_r && pwrite && hit_stat;

	// state
	wrf_pkg::wrf_ctrl_s ctrl_r, ctrl_nxt, ctrl_rd, wctl;
	wrf_pkg::wrf_stat_s stat_r, stat_nxt, wst;
	logic [2:0] ce_cnt_r, ce_cnt_nxt;
	logic [CNT_W-1:0] cnt_r, cnt_nxt, cnt_last;
	logic osc1_r, osc2_r, osc3_r;
	logic irq_r, irq_nxt, rst_r, rst_nxt;
	logic fuse_prog, reset_en_eff, irq_en_eff, any_reset, osc_edge, tmo, dog_rst;
	logic [3:0] ps_sel;
	wrf_pkg::wrf_mode_e mode;

	assign wctl = pwdata[wrf_pkg::REG_W-1:0];
	assign wst = pwdata[wrf_pkg::REG_W-1:0];
	assign fuse_prog = dog_always_on_fuse == wrf_pkg::FUSE_PROGRAMMED;
	assign reset_en_eff = ctrl_r.reset_en || stat_r.dog || fuse_prog;
	assign irq_en_eff = ctrl_r.irq_en && !fuse_prog;
	assign ps_sel = {ctrl_r.ps_hi, ctrl_r.ps_lo};

	always_comb begin
		unique case ({reset_en_eff, irq_en_eff})
			2'b00: mode = wrf_pkg::WRF_STOPPED;
			2'b01: mode = wrf_pkg::WRF_IRQ;
			2'b10: mode = wrf_pkg::WRF_RESET;
			2'b11: mode = wrf_pkg::WRF_IRQ_RESET;
		endcase
	end

	// time-out length; reserved codes run as the longest period
	always_comb begin
		if (ps_sel > wrf_pkg::DOG_PS_LAST) begin
			cnt_last = CNT_W'(wrf_pkg::DOG_MAX_CYC - 1);
		end else begin
			cnt_last = (CNT_W'(wrf_pkg::DOG_BASE_CYC) << ps_sel) - CNT_W'(1);
		end
	end

	// two-stage sampling, edge seen from the second stage on
	assign osc_edge = osc2_r && !osc3_r;
	assign tmo = osc_edge && mode != wrf_pkg::WRF_STOPPED && cnt_r == cnt_last;

	// fuse gives reset mode through reset_en_eff
	// pending flag at next time-out resets
	always_comb begin
		unique case (mode)
			wrf_pkg::WRF_RESET: dog_rst = tmo;
			wrf_pkg::WRF_IRQ_RESET: dog_rst = tmo && ctrl_r.irq_flag;
			default: dog_rst = 1'b0;
		endcase
	end
	assign any_reset = dog_rst || debug_port_reset_in || supply_drop_reset_in || pin_reset_in;

	// flag only rises when the time-out did not already turn into a reset
	logic irq_mode, irq_set, win_open;
	assign irq_mode = mode == wrf_pkg::WRF_IRQ || mode == wrf_pkg::WRF_IRQ_RESET;
	assign irq_set = tmo && irq_mode && !dog_rst;
	assign win_open = ctrl_r.change_en;

	always_comb begin
		ctrl_rd = ctrl_r;
		ctrl_rd.reset_en = reset_en_eff;
		ctrl_rd.irq_en = irq_en_eff;
	end

	// register file
	always_comb begin
		ctrl_nxt = ctrl_r;
		ce_cnt_nxt = ce_cnt_r;
		if (win_open) begin
			ce_cnt_nxt = ce_cnt_r - CE_LAST;
			if (ce_cnt_r == CE_LAST) begin
				ctrl_nxt.change_en = 1'b0;
			end
		end
		if (wr_ctrl) begin
			if (wctl.irq_flag) begin
				ctrl_nxt.irq_flag = 1'b0;
			end
			ctrl_nxt.irq_en = wctl.irq_en;
			if (wctl.reset_en) begin
				ctrl_nxt.reset_en = 1'b1;
			end
			// prescaler written, and reset_en cleared, only while window open
			if (win_open) begin
				ctrl_nxt.reset_en = wctl.reset_en;
				ctrl_nxt.ps_hi = wctl.ps_hi;
				ctrl_nxt.ps_lo = wctl.ps_lo;
				ctrl_nxt.change_en = 1'b0;
				ce_cnt_nxt = CE_IDLE;
			end
			if (wctl.change_en) begin
				ctrl_nxt.change_en = 1'b1;
				ce_cnt_nxt = wrf_pkg::CE_CNT_W3;
			end
		end
		// vector clears flag, and enable in combined mode
		if (irq_vector_taken) begin
			ctrl_nxt.irq_flag = 1'b0;
			if (mode == wrf_pkg::WRF_IRQ_RESET) begin
				ctrl_nxt.irq_en = 1'b0;
			end
		end
		if (irq_set) begin
			ctrl_nxt.irq_flag = 1'b1;
		end
		if (any_reset) begin
			ctrl_nxt = wrf_pkg::CTRL_RST;
			ce_cnt_nxt = CE_IDLE;
		end
	end

	always_comb begin
		stat_nxt = stat_r;
		// only a written zero clears power-on flag
		if (wr_stat) begin
			stat_nxt.debug_port = stat_r.debug_port && wst.debug_port;
			stat_nxt.dog = stat_r.dog && wst.dog;
			stat_nxt.supply_drop = stat_r.supply_drop && wst.supply_drop;
			stat_nxt.pin = stat_r.pin && wst.pin;
			stat_nxt.power_on = stat_r.power_on && wst.power_on;
		end
		if (debug_port_reset_in) begin
			stat_nxt.debug_port = 1'b1;
		end
		if (dog_rst) begin
			stat_nxt.dog = 1'b1;
		end
		if (supply_drop_reset_in) begin
			stat_nxt.supply_drop = 1'b1;
		end
		if (pin_reset_in) begin
			stat_nxt.pin = 1'b1;
		end
		stat_nxt.unused = 3'h0;
	end

	// restart on instruction, reset, stop or wrap
	always_comb begin
		cnt_nxt = cnt_r;
		if (dog_restart || any_reset || mode == wrf_pkg::WRF_STOPPED || tmo) begin
			cnt_nxt = '0;
		end else if (osc_edge) begin
			cnt_nxt = cnt_r + CNT_W'(1);
		end
	end

	always_comb begin
		irq_nxt = ctrl_nxt.irq_flag && ctrl_nxt.irq_en && !fuse_prog && global_irq_enable;
		rst_nxt = dog_rst;
	end

	always_comb begin
		pready_nxt = setup;
		pslverr_nxt = setup && !(hit_ctrl || hit_stat);
		prdata_nxt = prdata_r;
		if (setup) begin
			prdata_nxt = '0;
			if (hit_ctrl) begin
				prdata_nxt[wrf_pkg::REG_W-1:0] = ctrl_rd;
			end else if (hit_stat) begin
				prdata_nxt[wrf_pkg::REG_W-1:0] = stat_r;
			end
		end
	end

	// control register and change window
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_r <= wrf_pkg::CTRL_RST;
			ce_cnt_r <= CE_IDLE;
		end else begin
			ctrl_r <= ctrl_nxt;
			ce_cnt_r <= ce_cnt_nxt;
		end
	end

	// reset causes survive every reset but the power-on one
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			// power-on sets only its own flag
			stat_r <= wrf_pkg::STAT_POR;
		end else begin
			stat_r <= stat_nxt;
		end
	end

	// time-out counter
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	// oscillator sampling; the third stage only serves the edge detector
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			osc1_r <= 1'b0;
			osc2_r <= 1'b0;
			osc3_r <= 1'b0;
		end else begin
			osc1_r <= dog_osc_level;
			osc2_r <= osc1_r;
			osc3_r <= osc2_r;
		end
	end

	// request and reset outputs
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			irq_r <= 1'b0;
			rst_r <= 1'b0;
		end else begin
			irq_r <= irq_nxt;
			rst_r <= rst_nxt;
		end
	end

	// bus answer, one access cycle after setup
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			prdata_r <= '0;
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
		end else begin
			prdata_r <= prdata_nxt;
			pready_r <= pready_nxt;
			pslverr_r <= pslverr_nxt;
		end
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign dog_irq_req = irq_r;
	assign dog_sys_reset = rst_r;
endmodule
`default_nettype wire

// ### tb/wrf_watchdog_chk.sv
// Purpose: port-level assertions for the watchdog block
// Assumes: one clock domain, resetn asynchronous and active low
// Notes: watches only the pins that these relations need
`timescale 1ns/10ps
`default_nettype none
module wrf_watchdog_chk #(
	parameter int CNT_W = 20
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic dog_always_on_fuse,
	input wire logic global_irq_enable,
	input wire logic irq_vector_taken,
	input wire logic dog_irq_req,
	input wire logic dog_sys_reset
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	a_irq_req_gate: assert property (dog_irq_req |->
		$past(global_irq_enable) && $past(dog_always_on_fuse)) else $error("irq without enables");
	a_reset_pulse_one: assert property (dog_sys_reset |=> !dog_sys_reset)
		else $error("reset pulse too long");
	a_vector_drops_irq: assert property (irq_vector_taken |-> ##[1:3] !dog_irq_req)
		else $error("irq held after vector");
	a_ready_after_setup: assert property (psel && !penable |=> pready)
		else $error("no ready after setup");
	a_ready_single: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_ready_in_access: assert property (pready |-> psel && penable)
		else $error("ready outside access");
	a_err_zero_data: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
		else $error("error with data");
	a_upper_bits_zero: assert property (pready |-> prdata[31:8] == 24'h00_0000)
		else $error("upper read bits set");
	c_reset: cover property (dog_sys_reset);
	c_irq: cover property (dog_irq_req);
	c_err: cover property (pslverr);
	c_vector: cover property (irq_vector_taken && dog_irq_req);
endmodule
bind wrf_watchdog wrf_watchdog_chk #(.CNT_W(CNT_W)) wrf_watchdog_chk_i (
	.clk(clk), .resetn(resetn), .psel(psel), .penable(penable), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .dog_always_on_fuse(dog_always_on_fuse),
	.global_irq_enable(global_irq_enable), .irq_vector_taken(irq_vector_taken),
	.dog_irq_req(dog_irq_req), .dog_sys_reset(dog_sys_reset));
`default_nettype wire

// ### tb/wrf_watchdog_tb.sv
// Purpose: register-level bench for the watchdog
// Assumes: zero-wait APB slave, fast oscillator stand-in
// Notes: oscillator toggles every 2 clk so time-outs stay short
`timescale 1ns/10ps
`default_nettype none
module wrf_watchdog_tb;
	localparam logic [11:0] C = wrf_pkg::CTRL_ADDR;
	localparam logic [11:0] S = wrf_pkg::STAT_ADDR;
	logic clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, er;
	logic osc = 0, oc = 0, fuse = 1, gie = 1;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, rd;
	logic [4:0] pu = 0;
	logic pready, pslverr, dog_irq_req, dog_sys_reset;
	int num_errors = 0, compares = 0;
	int wn = 0;
	always #5 clk = ~clk;
	always @(posedge clk) begin
		oc <= ~oc;
		if (oc) osc <= ~osc;
	end
	wrf_watchdog wrf_watchdog_i (.clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .dog_osc_level(osc), .dog_always_on_fuse(fuse),
		.global_irq_enable(gie), .irq_vector_taken(pu[3]), .dog_restart(pu[4]),
		.debug_port_reset_in(pu[2]), .supply_drop_reset_in(pu[1]), .pin_reset_in(pu[0]),
		.dog_irq_req(dog_irq_req), .dog_sys_reset(dog_sys_reset));
	task end_of_test;
		if (num_errors == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] g, input logic [31:0] e);
		compares++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		@(posedge clk);
		// only the watchdog ends a wait for ready
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	task rc(input logic [11:0] a, input logic [31:0] e);
		apb(0, a, 0);
		chk("read", rd, e);
	endtask
	task pulse(input logic [4:0] m);
		@(posedge clk);
		pu <= m;
		@(posedge clk);
		pu <= 0;
	endtask
	// bounded wait for reset pulse or irq request
	task wt(input logic r);
		int n;
		n = 0;
		while ((r ? dog_sys_reset : dog_irq_req) !== 1'b1 && n < 20000) begin
			@(posedge clk);
			n++;
		end
		wn = n;
		chk("timeout seen", 32'(n < 20000), 32'h0000_0001);
	endtask
	initial begin
		repeat (90000) @(posedge clk);
		num_errors++;
		end_of_test;
	end
	initial begin
		repeat (5) @(posedge clk);
		resetn <= 1;
		rc(S, 32'h0000_0001);
		rc(C, 32'h0000_0000);
		apb(0, 12'h100, 0);
		chk("slverr", 32'(er), 32'h0000_0001);
		pulse(5'b00111);
		rc(S, 32'h0000_0017);
		apb(1, S, 0);
		rc(S, 32'h0000_0000);
		apb(1, C, 32'h0000_0008);
		apb(1, C, 32'h0000_0000);
		rc(C, 32'h0000_0008);
		apb(1, C, 32'h0000_0018);
		repeat (6) @(posedge clk);
		rc(C, 32'h0000_0008);
		apb(1, C, 32'h0000_0009);
		rc(C, 32'h0000_0008);
		pulse(5'b10000);
		apb(1, C, 32'h0000_0018);
		apb(1, C, 32'h0000_0041);
		rc(C, 32'h0000_0041);
		pulse(5'b10000);
		wt(0);
		chk("period", 32'(wn > 12000), 32'h0000_0001);
		rc(C, 32'h0000_00C1);
		gie <= 0;
		repeat (3) @(posedge clk);
		chk("irq req", 32'(dog_irq_req), 32'h0000_0000);
		gie <= 1;
		pulse(5'b10000);
		apb(1, C, 32'h0000_0058);
		apb(1, C, 32'h0000_00C0);
		rc(C, 32'h0000_0040);
		rc(S, 32'h0000_0000);
		apb(1, C, 32'h0000_0048);
		pulse(5'b10000);
		wt(0);
		pulse(5'b01000);
		rc(C, 32'h0000_0008);
		wt(1);
		rc(S, 32'h0000_0008);
		rc(C, 32'h0000_0008);
		apb(1, S, 0);
		apb(1, C, 32'h0000_0048);
		pulse(5'b10000);
		wt(0);
		wt(1);
		rc(S, 32'h0000_0008);
		apb(1, S, 0);
		fuse <= 0;
		apb(1, C, 32'h0000_0040);
		rc(C, 32'h0000_0008);
		pulse(5'b10000);
		wt(1);
		rc(S, 32'h0000_0008);
		end_of_test;
	end
endmodule
`default_nettype wire
